// ===== core/psg_defs.svh
// constants of the pll status and general control register block
`ifndef PSG_DEFS_SVH
`define PSG_DEFS_SVH

// ====================================================================
// register addresses (7-bit serial address field)
`define PSG_ADDR_STATUS    7'h70
`define PSG_ADDR_DIV_INIT  7'h71
`define PSG_ADDR_REACQUIRE 7'h72
`define PSG_ADDR_BIAS_EDGE 7'h73

// ====================================================================
// field positions
`define PSG_CMD_BIT        7
`define PSG_EDGE_BIT       0
`define PSG_ST_CAL_BIT     0
`define PSG_ST_PRESENT_BIT 1
`define PSG_ST_HOLD_BIT    2
`define PSG_ST_LATCH_BIT   3
`define PSG_ST_IE_BIT      4

// ====================================================================
// frame layout and reset values
`define PSG_FRAME_BITS     5'h10
`define PSG_HDR_BITS       5'h08
`define PSG_LAST_BIT       5'h0F
`define PSG_EDGE_RESET     1'h0
`define PSG_IE_RESET       1'h0
// synchroniser resting values: sclk, cs_n, serial_data_line, cal, ref, hold, done
`define PSG_SYNC_RESET     7'h22

`endif

// ===== core/psg_pkg.sv
// types of the pll status and general control register block
package psg_pkg;
   // serial frame phase
   typedef enum logic [1:0] {
      PSG_IDLE = 2'b00,   // chip select high
      PSG_HDR  = 2'b01,   // shifting read flag and address
      PSG_DATA = 2'b10    // data byte in or out
   } psg_phase_e;
endpackage

// ===== core/psg_regs.sv
// serial-port register block for pll status and general control
`timescale 1ns/10ps
`include "psg_defs.svh"

module psg_regs
   import psg_pkg::*;
(
   input  wire logic ref_clk_i,                // 25 MHz core clock
   input  wire logic reset_i,                  // synchronous, active high
   input  wire logic sclk_i,                   // serial clock pin
   input  wire logic cs_n_i,                   // serial select, active low
   input  wire logic serial_data_line_i,       // data pin, input side
   output logic      serial_data_line_o,       // data pin, output side
   output logic      serial_data_line_oe_o,    // high while we drive
   input  wire logic synth_cal_active_i,       // second pll calibrating
   input  wire logic reference_present_i,      // input reference seen
   input  wire logic holdover_now_n_i,         // low while in holdover
   input  wire logic bias_cal_done_i,          // bias calibration done
   output logic      irq_out_n_o,              // interrupt, active low
   output logic      divider_init_o,           // one-cycle divider init
   output logic      force_pll_reacquire_o,    // one-cycle force_pll_reacquire pulse
   output logic      bias_calibrate_start_o    // high while bias cal runs
);

   // ====================================================================
   // input synchronisers
   localparam int NSYNC = 7;
   localparam int I_SCLK = 0;
   localparam int I_CSN  = 1;
   localparam int I_SDI  = 2;
   localparam int I_CAL  = 3;
   localparam int I_REF  = 4;
   localparam int I_HOLD = 5;
   localparam int I_DONE = 6;
   localparam logic [NSYNC-1:0] SYNC_RST = `PSG_SYNC_RESET; // idle levels

   logic [NSYNC-1:0] raw;      // pin levels
   logic [NSYNC-1:0] s1_q;     // first stage, read only by s2
   logic [NSYNC-1:0] s2_q;     // second stage
   logic [NSYNC-1:0] s3_q;     // third stage
   logic [NSYNC-1:0] f_q;      // accepted level
   logic [NSYNC-1:0] f_prev_q; // previous accepted level

   assign raw = {bias_cal_done_i, holdover_now_n_i, reference_present_i,
                 synth_cal_active_i, serial_data_line_i, cs_n_i, sclk_i};

   // three flops each; a change counts once stages two and three agree,
   // so a pin caught mid-transition is never taken on its first sample
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         s1_q     <= SYNC_RST;
         s2_q     <= SYNC_RST;
         s3_q     <= SYNC_RST;
         f_q      <= SYNC_RST;
         f_prev_q <= SYNC_RST;
      end else begin
         s1_q     <= raw;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         f_prev_q <= f_q;
         // agreeing bits take stage three, disagreeing bits hold
         f_q      <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
      end
   end

   logic sck_rise;   // accepted sclk rising edge
   logic sck_fall;   // accepted sclk falling edge
   logic sel;        // chip selected
   assign sck_rise = f_q[I_SCLK] & ~f_prev_q[I_SCLK];
   assign sck_fall = ~f_q[I_SCLK] & f_prev_q[I_SCLK];
   assign sel      = ~f_q[I_CSN];

   // ====================================================================
   // register state
   logic       latch_n_q;   // latched holdover, low once holdover seen
   logic       ie_q;        // holdover interrupt enable
   logic       edge_q;      // read launch edge select
   logic       bias_q;      // bias calibration running
   logic       wr_stb;      // write commit, one cycle
   logic [6:0] wr_addr;     // committed address
   logic [7:0] wr_data;     // committed data
   logic [7:0] rd_mux;      // read value for current header

   // ====================================================================
   // serial frame engine
   psg_phase_e phase_q;     // frame phase
   logic [4:0] cnt_q;       // rising edges seen this frame
   logic [7:0] hdr_q;       // read flag and address
   logic [7:0] din_q;       // write data shift
   logic [7:0] rd_q;        // read snapshot
   logic       launch;      // read bit launch event
   logic       is_read;     // header marks a read

   assign is_read = hdr_q[7];
   // read data moves on the chosen edge
   assign launch  = edge_q ? sck_rise : sck_fall;
   assign wr_stb  = sel && sck_rise && phase_q == PSG_DATA && !is_read
                    && cnt_q == `PSG_LAST_BIT;
   assign wr_addr = hdr_q[6:0];
   assign wr_data = {din_q[6:0], f_q[I_SDI]};

   // phase and bit count
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !sel) begin
         phase_q <= PSG_IDLE;
         cnt_q   <= 5'h00;
      end else begin
         case (phase_q)
            PSG_IDLE: begin
               phase_q <= PSG_HDR;
            end
            PSG_HDR: begin
               if (sck_rise) begin
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == `PSG_HDR_BITS - 5'h01) begin
                     phase_q <= PSG_DATA;
                  end
               end
            end
            PSG_DATA: begin
               // extra clocks past the frame are ignored
               if (sck_rise && cnt_q != `PSG_FRAME_BITS) begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            default: begin
               phase_q <= PSG_IDLE;
            end
         endcase
      end
   end

   // shift header and write data, msb first, on rising edges
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         hdr_q <= 8'h00;
         din_q <= 8'h00;
      end else if (sel && sck_rise) begin
         if (phase_q == PSG_HDR) begin
            hdr_q <= {hdr_q[6:0], f_q[I_SDI]};
         end else if (phase_q == PSG_DATA) begin
            din_q <= {din_q[6:0], f_q[I_SDI]};
         end
      end
   end

   // read output: snapshot on first launch, then shift
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !sel) begin
         rd_q                  <= 8'h00;
         serial_data_line_o    <= 1'b0;
         serial_data_line_oe_o <= 1'b0;
      end else if (phase_q == PSG_DATA && is_read && launch
                   && cnt_q < `PSG_FRAME_BITS) begin
         serial_data_line_oe_o <= 1'b1;
         if (cnt_q == `PSG_HDR_BITS) begin
            // snapshot keeps a changing status from tearing the byte
            rd_q               <= rd_mux;
            serial_data_line_o <= rd_mux[7];
         end else begin
            serial_data_line_o <= rd_q[3'(`PSG_LAST_BIT - cnt_q)];
         end
      end
   end

   // read value; reserved and write-only bits read as zero
   always_comb begin
      rd_mux = 8'h00;
      case (hdr_q[6:0])
         `PSG_ADDR_STATUS: begin
            rd_mux[`PSG_ST_CAL_BIT]   = f_q[I_CAL];
            rd_mux[`PSG_ST_PRESENT_BIT] = f_q[I_REF];
            rd_mux[`PSG_ST_HOLD_BIT]  = f_q[I_HOLD];
            rd_mux[`PSG_ST_LATCH_BIT] = latch_n_q;
            rd_mux[`PSG_ST_IE_BIT]    = ie_q;
         end
         `PSG_ADDR_BIAS_EDGE: begin
            rd_mux[`PSG_EDGE_BIT] = edge_q;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // ====================================================================
   // holdover latch and interrupt
   // holdover sets the latch low; it wins over a same-cycle clear
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         latch_n_q <= 1'b1;
      end else if (!f_q[I_HOLD]) begin
         latch_n_q <= 1'b0;
      end else if (wr_stb && wr_addr == `PSG_ADDR_STATUS
                   && wr_data[`PSG_ST_LATCH_BIT]) begin
         latch_n_q <= 1'b1;
      end
   end

   // enable write and registered interrupt pin
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ie_q        <= `PSG_IE_RESET;
         irq_out_n_o <= 1'b1;
      end else begin
         if (wr_stb && wr_addr == `PSG_ADDR_STATUS) begin
            ie_q <= wr_data[`PSG_ST_IE_BIT];
         end
         irq_out_n_o <= ~(ie_q & ~latch_n_q);
      end
   end

   // ====================================================================
   // command bits
   // self-clearing pulses: they never store, so nothing reads back
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         divider_init_o        <= 1'b0;
         force_pll_reacquire_o <= 1'b0;
      end else begin
         divider_init_o <= wr_stb && wr_addr == `PSG_ADDR_DIV_INIT
                           && wr_data[`PSG_CMD_BIT];
         force_pll_reacquire_o <= wr_stb && wr_addr == `PSG_ADDR_REACQUIRE
                           && wr_data[`PSG_CMD_BIT];
      end
   end

   // bias calibration and read edge select
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         bias_q <= 1'b0;
         edge_q <= `PSG_EDGE_RESET;
      end else begin
         if (wr_stb && wr_addr == `PSG_ADDR_BIAS_EDGE) begin
            edge_q <= wr_data[`PSG_EDGE_BIT];
         end
         if (wr_stb && wr_addr == `PSG_ADDR_BIAS_EDGE
             && wr_data[`PSG_CMD_BIT]) begin
            bias_q <= 1'b1;
         end else if (f_q[I_DONE]) begin
            bias_q <= 1'b0;
         end
      end
   end
   assign bias_calibrate_start_o = bias_q;

   // ====================================================================
   // assertions
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   sequence div_cmd_s;
      wr_stb && wr_addr == `PSG_ADDR_DIV_INIT && wr_data[7];
   endsequence
   sequence one_pulse_div_s;
      divider_init_o ##1 !divider_init_o;
   endsequence

   hold_latch_a: assert property (
      !f_q[I_HOLD] |=> !latch_n_q)
      else $error("holdover not latched");
   hold_clear_a: assert property (
      wr_stb && wr_addr == `PSG_ADDR_STATUS && wr_data[3] && f_q[I_HOLD]
      |=> latch_n_q)
      else $error("latch clear lost");
   irq_on_a: assert property (
      ie_q && !latch_n_q |=> !irq_out_n_o)
      else $error("interrupt not raised");
   irq_off_a: assert property (
      !ie_q |=> irq_out_n_o)
      else $error("interrupt while disabled");
   div_pulse_a: assert property (
      div_cmd_s |=> one_pulse_div_s)
      else $error("divider init pulse wrong");
   reacquire_pulse_a: assert property (
      force_pll_reacquire_o |-> $past(wr_stb) && $past(wr_addr) == 7'h72)
      else $error("stray force_pll_reacquire pulse");
   bias_start_a: assert property (
      wr_stb && wr_addr == `PSG_ADDR_BIAS_EDGE && wr_data[7]
      |=> bias_calibrate_start_o)
      else $error("bias calibration not started");
   bias_hold_a: assert property (
      bias_q && !f_q[I_DONE] && !$past(f_q[I_DONE]) |=> bias_q)
      else $error("bias command cleared early");
   edge_write_a: assert property (
      wr_stb && wr_addr == `PSG_ADDR_BIAS_EDGE
      |=> edge_q == $past(wr_data[0]))
      else $error("read edge not stored");
   cal_read_a: assert property (
      hdr_q[6:0] == `PSG_ADDR_STATUS |-> rd_mux[0] == f_q[I_CAL]
      && rd_mux[1] == f_q[I_REF] && rd_mux[7:5] == 3'h0)
      else $error("status read wrong");
   drive_off_a: assert property (
      !sel |=> !serial_data_line_oe_o)
      else $error("data line driven while deselected");

endmodule

// ===== dv/psg_host_model.sv
// serial host model for the three-wire configuration port
`timescale 1ns/10ps

// ====================================================================
// host side: paces the serial clock from the core clock
module psg_host_model (
   input  wire logic ref_clk_i,   // core clock, paces the serial clock
   output logic      sclk_o,      // serial clock, low outside frames
   output logic      cs_n_o,      // select, active low
   input  wire logic dev_data_i,  // device data output
   input  wire logic dev_oe_i,    // device drive enable
   output logic      line_o       // resolved data wire
);
   logic host_d  = 1'b0;          // host data value
   logic host_oe = 1'b0;          // host drives header and write data

   // the wire has a pull-up, so a released line reads high
   assign line_o = dev_oe_i ? dev_data_i : (host_oe ? host_d : 1'b1);

   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
   end

   // one frame of 8 core clocks per serial bit, 320 ns period;
   // a 17th cell without a rise lets the last rising-edge bit be seen
   task automatic frame(input logic rd, input logic [6:0] addr,
                        input logic [7:0] wdata, input logic sel,
                        output logic [7:0] rdata);
      logic [15:0] bits;
      int          k;
      int          c;
      bits  = {rd, addr, wdata};
      rdata = 8'h00;
      @(posedge ref_clk_i);
      cs_n_o <= 1'b0;
      for (k = 0; k < 17; k++) begin
         for (c = 0; c < 8; c++) begin
            @(posedge ref_clk_i);
            if (c == 0) begin
               sclk_o  <= 1'b0;
               host_oe <= (k < 8) || (!rd && k < 16);
               host_d  <= bits[15];
               bits     = bits << 1;
            end
            if (c == 4 && k < 16) begin
               sclk_o <= 1'b1;
            end
            // sample seven clocks after the launch edge of each bit
            if (rd && c == (sel ? 3 : 7) && k >= 8 + sel && k <= 15 + sel)
            begin
               rdata = {rdata[6:0], line_o};
            end
         end
      end
      cs_n_o  <= 1'b1;
      host_oe <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
   endtask
endmodule

// ===== dv/psg_regs_tb.sv
// self-checking testbench of the pll status and control registers
`timescale 1ns/10ps

// ====================================================================
// clock, reset, device under test and serial host
module psg_regs_tb;
   logic       ref_clk_i = 1'b0;   // 25 MHz core clock
   logic       reset_i   = 1'b1;   // synchronous reset
   logic       sclk, cs_n, line, dev_d, dev_oe, irq_n, div, rel, bias;
   logic       cal    = 1'b0;      // second pll calibrating
   logic       refp   = 1'b0;      // reference present
   logic       hold_n = 1'b1;      // low in holdover
   logic       done   = 1'b0;      // bias calibration finished
   logic       edge_sel = 1'b0;    // read edge the host expects
   logic [7:0] n_div = 8'h00;      // cycles with divider init high
   logic [7:0] n_rel = 8'h00;      // cycles with force_pll_reacquire high
   int         err_total  = 0;
   int         n_compared = 0;
   int         i;

   always #20 ref_clk_i = ~ref_clk_i;

   psg_regs u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .sclk_i(sclk), .cs_n_i(cs_n), .serial_data_line_i(line),
      .serial_data_line_o(dev_d), .serial_data_line_oe_o(dev_oe),
      .synth_cal_active_i(cal), .reference_present_i(refp),
      .holdover_now_n_i(hold_n), .bias_cal_done_i(done),
      .irq_out_n_o(irq_n), .divider_init_o(div),
      .force_pll_reacquire_o(rel), .bias_calibrate_start_o(bias));

   psg_host_model u_host (.ref_clk_i(ref_clk_i), .sclk_o(sclk),
      .cs_n_o(cs_n), .dev_data_i(dev_d), .dev_oe_i(dev_oe),
      .line_o(line));

   // pulse counters: a one-cycle pulse adds exactly one
   always @(posedge ref_clk_i) begin
      if (div === 1'b1) n_div <= n_div + 8'h01;
      if (rel === 1'b1) n_rel <= n_rel + 8'h01;
   end

   // ================================================================
   // compare, access and closing tasks
   task automatic fail(input string msg);
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
   endtask
   task automatic chk1(input logic got, input logic exp, input string m);
      n_compared++;
      if (got !== exp) fail(m);
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
      n_compared++;
      if (got !== exp) fail(m);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] unused;
      u_host.frame(1'b0, a, d, edge_sel, unused);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] got;
      u_host.frame(1'b1, a, 8'h00, edge_sel, got);
      chk8(got, exp, "read data");
   endtask
   task automatic settle();
      repeat (10) @(posedge ref_clk_i);
   endtask
   task automatic results();
      $display("compares %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // watchdog: the tests need about 5000 clocks
   initial begin
      repeat (30000) @(posedge ref_clk_i);
      fail("watchdog expired");
      results();
   end

   // ================================================================
   // test sequence
   initial begin
      repeat (6) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      settle();
      chk1(irq_n, 1'b1, "irq after reset");
      chk1(dev_oe, 1'b0, "oe after reset");
      // start-up: dividers first, then bias calibration
      wr(7'h71, 8'h80);
      settle();
      chk8(n_div, 8'h01, "divider init pulse");
      wr(7'h73, 8'h80);
      repeat (40) @(posedge ref_clk_i);
      chk1(bias, 1'b1, "bias cal running");
      done <= 1'b1;
      settle();
      chk1(bias, 1'b0, "bias cal ended");
      done <= 1'b0;
      $display("test startup done");
      // momentary status for all four cal and reference combinations, holdover off
      for (i = 0; i < 4; i++) begin
         cal  <= i[0];
         refp <= i[1];
         settle();
         rd_chk(7'h70, {6'b000011, i[1], i[0]});
      end
      hold_n <= 1'b0;
      settle();
      rd_chk(7'h70, 8'h03);
      chk1(irq_n, 1'b1, "irq while disabled");
      hold_n <= 1'b1;
      settle();
      rd_chk(7'h70, 8'h07);
      wr(7'h70, 8'h10);
      settle();
      chk1(irq_n, 1'b0, "irq enabled on latch");
      wr(7'h70, 8'h18);
      settle();
      chk1(irq_n, 1'b1, "irq after clear");
      rd_chk(7'h70, 8'h1F);
      hold_n <= 1'b0;
      settle();
      hold_n <= 1'b1;
      settle();
      chk1(irq_n, 1'b0, "irq on short holdover");
      rd_chk(7'h70, 8'h17);
      wr(7'h70, 8'h08);
      settle();
      chk1(irq_n, 1'b1, "irq cleared");
      $display("test holdover done");
      // command bits, reserved bits and an unmapped address
      wr(7'h71, 8'h00);
      wr(7'h72, 8'h80);
      wr(7'h71, 8'h7F);
      wr(7'h72, 8'h7F);
      wr(7'h05, 8'hFF);
      settle();
      chk8(n_div, 8'h01, "divider pulses");
      chk8(n_rel, 8'h01, "force_pll_reacquire pulses");
      rd_chk(7'h71, 8'h00);
      rd_chk(7'h72, 8'h00);
      rd_chk(7'h05, 8'h00);
      $display("test commands done");
      // read edge select both ways
      wr(7'h73, 8'h01);
      edge_sel = 1'b1;
      rd_chk(7'h73, 8'h01);
      rd_chk(7'h70, 8'h0F);
      wr(7'h73, 8'h00);
      edge_sel = 1'b0;
      rd_chk(7'h73, 8'h00);
      chk1(bias, 1'b0, "bias idle");
      $display("test read edge done");
      // mid-run reset returns control bits to their resting values
      wr(7'h73, 8'h01);
      wr(7'h70, 8'h10);
      hold_n <= 1'b0;
      settle();
      hold_n <= 1'b1;
      settle();
      chk1(irq_n, 1'b0, "irq before reset");
      reset_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      settle();
      chk1(irq_n, 1'b1, "irq after second reset");
      chk1(dev_oe, 1'b0, "oe after second reset");
      rd_chk(7'h73, 8'h00);
      rd_chk(7'h70, 8'h0F);
      $display("test mid-run reset done");
      results();
   end
endmodule
